// *** atm_pkg.sv ***
// Shared constants for the alarm trigger monitor
package atm_pkg;
  localparam int NUM_TRIG = 8;
  localparam int TIME_W = 15;
  localparam int GROUP_W = 6;
  // Timing base
  localparam longint CLK_PERIOD_NS = 10;
  localparam longint TICK_PERIOD_MS = 1000;
  localparam longint TICK_CYCLES_DEF = (TICK_PERIOD_MS * 64'd1000000) / CLK_PERIOD_NS;
  // Timer limits in seconds
  localparam logic [TIME_W-1:0] MIN_CTRL_S = 15'h0001;
  localparam logic [TIME_W-1:0] MIN_CLK_S = 15'h0002;
  localparam logic [TIME_W-1:0] MIN_DATA_S = 15'h0004;
  localparam logic [TIME_W-1:0] MAX_ALARM_S = 15'h5460;
  localparam logic [TIME_W-1:0] IGNORE_S = 15'h0002;
  // Lead select codes
  localparam logic [2:0] LEAD_RTS = 3'h0;
  localparam logic [2:0] LEAD_CTS = 3'h1;
  localparam logic [2:0] LEAD_DCD = 3'h2;
  localparam logic [2:0] LEAD_DTR = 3'h3;
  localparam logic [2:0] LEAD_RXCLK = 3'h4;
  localparam logic [2:0] LEAD_TXCLK = 3'h5;
  localparam logic [2:0] LEAD_RXD = 3'h6;
  localparam logic [2:0] LEAD_TXD = 3'h7;
  // Switching target and action codes
  typedef enum logic [1:0] {
    TGT_NONE = 2'b00,
    TGT_CIRCUIT = 2'b01,
    TGT_RACK = 2'b10,
    TGT_GROUP = 2'b11
  } atm_target_type;
  typedef enum logic [1:0] {
    ACT_ALTERNATE = 2'b00,
    ACT_FORCE_A = 2'b01,
    ACT_FORCE_B = 2'b10
  } atm_action_type;
endpackage

// *** atm_monitor.sv ***
// Alarm trigger monitor: eight timed triggers per circuit with auto switch request
`timescale 1ns/1ps
module atm_monitor
  import atm_pkg::*;
#(
  parameter longint TICK_CYCLES = TICK_CYCLES_DEF
)(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic lead_rts_i,
  input wire logic lead_cts_i,
  input wire logic lead_dcd_i,
  input wire logic lead_dtr_i,
  input wire logic lead_rxclk_i,
  input wire logic lead_txclk_i,
  input wire logic lead_rxd_i,
  input wire logic lead_txd_i,
  input wire logic switching_circuit_i,
  input wire logic [NUM_TRIG-1:0] enable_i,
  input wire logic [NUM_TRIG*3-1:0] lead_sel_i,
  input wire logic [NUM_TRIG-1:0] alarm_level_i,
  input wire logic [NUM_TRIG*TIME_W-1:0] alarm_time_i,
  input wire logic [NUM_TRIG*TIME_W-1:0] clear_time_i,
  input wire logic [NUM_TRIG-1:0] beep_en_i,
  input wire logic [NUM_TRIG-1:0] led_en_i,
  input wire logic [NUM_TRIG*2-1:0] sw_target_i,
  input wire logic [NUM_TRIG*2-1:0] sw_action_i,
  input wire logic [NUM_TRIG*GROUP_W-1:0] sw_group_i,
  output logic [NUM_TRIG-1:0] alarm_o,
  output logic beep_o,
  output logic led_o,
  output logic ignore_o,
  output logic switch_req_o,
  output logic [1:0] switch_target_o,
  output logic [1:0] switch_action_o,
  output logic [GROUP_W-1:0] switch_group_o
);

  logic [31:0] div_r;
  logic tick_r;
  logic [3:0] prev_r;
  logic [3:0] seen_r;
  logic [3:0] act_r;
  logic [3:0] evt;
  logic [7:0] lead_state;
  logic [NUM_TRIG-1:0] alarm_r;
  logic [NUM_TRIG-1:0] alarm_nxt;
  logic [TIME_W-1:0] ign_r;
  logic ignoring;
  logic [NUM_TRIG-1:0] fire;
  logic req_nxt;
  logic [1:0] tgt_nxt;
  logic [1:0] act_nxt;
  logic [GROUP_W-1:0] grp_nxt;

  // Lowest timer bound allowed for the lead class
  function automatic logic [TIME_W-1:0] class_min(input logic [2:0] sel);
    if (sel >= LEAD_RXD)
      return MIN_DATA_S;
    else if (sel >= LEAD_RXCLK)
      return MIN_CLK_S;
    else
      return MIN_CTRL_S;
  endfunction

  // One-second tick shared by every timer
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      div_r <= 32'h0;
      tick_r <= 1'b0;
    end
    else if (div_r >= 32'(TICK_CYCLES - 1))
    begin
      div_r <= 32'h0;
      tick_r <= 1'b1;
    end
    else
    begin
      div_r <= div_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  // Clock edges and data spaces seen within the current second
  assign evt[0] = lead_rxclk_i ^ prev_r[0];
  assign evt[1] = lead_txclk_i ^ prev_r[1];
  assign evt[2] = !lead_rxd_i;
  assign evt[3] = !lead_txd_i;

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      prev_r <= 4'h0;
      seen_r <= 4'h0;
      act_r <= 4'h0;
    end
    else
    begin
      prev_r <= {lead_txd_i, lead_rxd_i, lead_txclk_i, lead_rxclk_i};
      if (tick_r)
      begin
        act_r <= seen_r | evt; // Window closes; late event still counts
        seen_r <= 4'h0;
      end
      else
        seen_r <= seen_r | evt;
    end
  end

  // Classified state of every lead, high means ON, PRESENT or ACTIVE
  assign lead_state = {act_r[3], act_r[2], act_r[1], act_r[0],
                       lead_dtr_i, lead_dcd_i, lead_cts_i, lead_rts_i};

  assign ignoring = (ign_r != 15'h0);

  // Per trigger confirmation timers
  generate
    for (genvar g = 0; g < NUM_TRIG; g++)
    begin : g_trig
      logic [TIME_W-1:0] cnt_r;
      logic [TIME_W-1:0] cfg_a;
      logic [TIME_W-1:0] cfg_c;
      logic [TIME_W-1:0] min_t;
      logic [TIME_W-1:0] alarm_t;
      logic [TIME_W-1:0] clear_t;
      logic [2:0] sel;
      logic cond;

      assign sel = lead_sel_i[g*3 +: 3];
      assign cfg_a = alarm_time_i[g*TIME_W +: TIME_W];
      assign cfg_c = clear_time_i[g*TIME_W +: TIME_W];
      assign min_t = class_min(sel);
      // Clamp both to class minimum; only the alarm time to the six hour ceiling
      assign alarm_t = (cfg_a < min_t) ? min_t :
                       ((cfg_a > MAX_ALARM_S) ? MAX_ALARM_S : cfg_a);
      assign clear_t = (cfg_c < min_t) ? min_t : cfg_c;
      assign cond = (lead_state[sel] == alarm_level_i[g]);

      // Next alarm state, recognized only after full continuous time
      always_comb
      begin
        alarm_nxt[g] = alarm_r[g];
        if (!enable_i[g])
          alarm_nxt[g] = 1'b0;
        else if (tick_r && !ignoring)
        begin
          if (!alarm_r[g] && cond && (cnt_r + 15'h1 >= alarm_t))
            alarm_nxt[g] = 1'b1;
          else if (alarm_r[g] && !cond && (cnt_r + 15'h1 >= clear_t))
            alarm_nxt[g] = 1'b0;
        end
      end

      always_ff @(posedge core_clk_i)
      begin
        if (!resetn_i)
          cnt_r <= 15'h0;
        else if (!enable_i[g] || ignoring)
          cnt_r <= 15'h0;
        else if (tick_r)
        begin
          if ((cond != alarm_r[g]) && (alarm_nxt[g] == alarm_r[g]))
            cnt_r <= cnt_r + 15'h1;
          else
            cnt_r <= 15'h0; // Restart on interruption
        end
      end

      assign fire[g] = alarm_nxt[g] && !alarm_r[g];
    end
  endgenerate

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      alarm_r <= '0;
    else
      alarm_r <= alarm_nxt;
  end

  // Pick the lowest recognized trigger with a switching target
  always_comb
  begin
    req_nxt = 1'b0;
    tgt_nxt = TGT_NONE;
    act_nxt = ACT_ALTERNATE;
    grp_nxt = '0;
    for (int i = NUM_TRIG - 1; i >= 0; i--)
    begin
      if (fire[i] && (sw_target_i[i*2 +: 2] != TGT_NONE) && switching_circuit_i)
      begin
        req_nxt = 1'b1;
        tgt_nxt = sw_target_i[i*2 +: 2];
        act_nxt = sw_action_i[i*2 +: 2];
        grp_nxt = sw_group_i[i*GROUP_W +: GROUP_W];
      end
    end
  end

  // Switch request outputs
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      switch_req_o <= 1'b0;
      switch_target_o <= TGT_NONE;
      switch_action_o <= ACT_ALTERNATE;
      switch_group_o <= '0;
    end
    else
    begin
      switch_req_o <= req_nxt;
      if (req_nxt)
      begin
        switch_target_o <= tgt_nxt;
        switch_action_o <= act_nxt;
        switch_group_o <= grp_nxt;
      end
    end
  end

  // Fixed ignore interval after a switch
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      ign_r <= 15'h0;
    else if (req_nxt)
      ign_r <= IGNORE_S;
    else if (tick_r && ignoring)
      ign_r <= ign_r - 15'h1;
  end

  // Indications at the rack
  assign alarm_o = alarm_r;
  assign beep_o = |(alarm_r & beep_en_i);
  assign led_o = |(alarm_r & led_en_i);
  assign ignore_o = ignoring;

  ign_start_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    switch_req_o |-> ignore_o && (ign_r == IGNORE_S))
    else $error("ignore interval not started by switch");
  ign_freeze_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ignore_o && !$fell(resetn_i) |=> (alarm_r & enable_i) == ($past(alarm_r) & enable_i))
    else $error("alarm state changed while ignoring");
  sw_gate_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    switch_req_o |-> $past(switching_circuit_i))
    else $error("switch on non switching circuit");
  sw_target_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    switch_req_o |-> switch_target_o != TGT_NONE)
    else $error("switch request with no target");
  sw_cause_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    switch_req_o |-> (alarm_r & ~$past(alarm_r)) != '0)
    else $error("switch without a new alarm");
  sw_single_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    switch_req_o |=> !switch_req_o [*8])
    else $error("second switch inside ignore interval");
  alarm_tick_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (alarm_r & ~$past(alarm_r)) != '0 |-> $past(tick_r))
    else $error("alarm recognized off the second tick");
  trig_en_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ($past(~enable_i) & alarm_r) == '0)
    else $error("disabled trigger holds an alarm");
  beep_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $rose(alarm_o[0]) && beep_en_i[0] |-> beep_o)
    else $error("beep missing on alarm");
  tick_gap_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    tick_r && TICK_CYCLES > 1 |=> !tick_r)
    else $error("tick wider than one cycle");

endmodule

// *** atm_leads.sv ***
// Far-side lead model driving the circuit's interface leads
`timescale 1ns/1ps
module atm_leads (
  input wire logic clk_i,
  input wire logic [3:0] ctrl_i,
  input wire logic [1:0] clk_run_i,
  input wire logic [1:0] data_act_i,
  output logic [7:0] leads_o
);
  logic ph_r;

  // Free phase used for clock toggling and data spaces
  initial ph_r = 1'b0;
  always @(negedge clk_i)
  begin
    ph_r <= ~ph_r;
  end

  // Data rests at marks when idle; stopped clocks sit low
  always_comb
  begin
    leads_o = {~data_act_i | {2{ph_r}}, clk_run_i & {2{ph_r}}, ctrl_i};
  end
endmodule

// *** tb.sv ***
// Self-checking testbench for the alarm trigger monitor
`timescale 1ns/1ps
module tb
  import atm_pkg::*;
;
  logic clk, rstn, swc, beep, led, ign, req;
  logic [3:0] ctrl;
  logic [1:0] crun, dact, stgt, sact;
  logic [7:0] leads, en, lvl, bp, ld, alarm;
  logic [23:0] sel;
  logic [119:0] at, ct;
  logic [15:0] tg, ac;
  logic [47:0] gp;
  logic [5:0] sgrp;
  int fail_count, cmp_count, cyc, nreq, n, keep;

  atm_leads i_leads (.clk_i(clk), .ctrl_i(ctrl), .clk_run_i(crun), .data_act_i(dact),
    .leads_o(leads));
  atm_monitor #(.TICK_CYCLES(20)) i_dut (.core_clk_i(clk), .resetn_i(rstn),
    .lead_rts_i(leads[0]), .lead_cts_i(leads[1]), .lead_dcd_i(leads[2]),
    .lead_dtr_i(leads[3]), .lead_rxclk_i(leads[4]), .lead_txclk_i(leads[5]),
    .lead_rxd_i(leads[6]), .lead_txd_i(leads[7]), .switching_circuit_i(swc),
    .enable_i(en), .lead_sel_i(sel), .alarm_level_i(lvl), .alarm_time_i(at),
    .clear_time_i(ct), .beep_en_i(bp), .led_en_i(ld), .sw_target_i(tg),
    .sw_action_i(ac), .sw_group_i(gp), .alarm_o(alarm), .beep_o(beep), .led_o(led),
    .ignore_o(ign), .switch_req_o(req), .switch_target_o(stgt),
    .switch_action_o(sact), .switch_group_o(sgrp));

  // Clock generation
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cycle ceiling and switch pulse count
  always @(posedge clk)
  begin
    cyc++;
    if (req === 1'b1) nreq++;
    if (cyc > 5000)
    begin
      fail_count++;
      conclude();
    end
  end

  task conclude;
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task rng(input int v, input int lo, input int hi);
    cmp_count++;
    if (v < lo || v > hi)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask

  // Enable one trigger alone with the given settings
  task cfg(input int i, input logic [2:0] s, input logic l, input logic [14:0] a,
    input logic [14:0] c, input logic [1:0] t, input logic [1:0] x, input logic [5:0] g,
    input logic b, input logic v);
    en = 8'h01 << i;
    sel[i*3+:3] = s;
    lvl[i] = l;
    at[i*TIME_W+:TIME_W] = a;
    ct[i*TIME_W+:TIME_W] = c;
    tg[i*2+:2] = t;
    ac[i*2+:2] = x;
    gp[i*GROUP_W+:GROUP_W] = g;
    bp[i] = b;
    ld[i] = v;
  endtask

  task wt(input int i, input logic v, output int c);
    c = 0;
    while (alarm[i] !== v && c < 200)
    begin
      @(negedge clk);
      c++;
    end
  endtask

  task wign(output int c);
    c = 0;
    while (ign !== 1'b0 && c < 200)
    begin
      @(negedge clk);
      c++;
    end
  endtask

  // Main sequence
  initial
  begin
    {rstn, swc, ctrl, crun, dact, en, lvl, bp, ld, sel, at, ct, tg, ac, gp} = '0;
    {fail_count, cmp_count, cyc, nreq} = '0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    swc = 1'b1;
    chk({alarm, beep, led, ign, req}, 32'h0);
    // Control lead alarm and clear with three-second timers, no switching
    cfg(0, LEAD_RTS, 1'b1, 15'h0003, 15'h0003, TGT_NONE, ACT_ALTERNATE, 6'h00, 1'b1, 1'b0);
    ctrl = 4'h1;
    repeat (40) @(negedge clk);
    ctrl = 4'h0; // Break the condition across one tick
    repeat (20) @(negedge clk);
    chk(alarm, 32'h0);
    ctrl = 4'h1;
    wt(0, 1'b1, n);
    rng(n, 40, 62);
    chk({beep, led, req}, 32'h4);
    ctrl = 4'h0;
    wt(0, 1'b0, n);
    rng(n, 40, 62);
    chk(nreq, 32'h0);
    // Zero alarm time raised to one second, switch to side B
    cfg(2, LEAD_DCD, 1'b1, 15'h0000, 15'h0001, TGT_CIRCUIT, ACT_FORCE_B, 6'h05, 1'b0, 1'b1);
    ctrl = 4'h4;
    wt(2, 1'b1, n);
    rng(n, 0, 22);
    chk({req, ign, led, beep}, 32'he);
    chk({stgt, sact, sgrp}, {TGT_CIRCUIT, ACT_FORCE_B, 6'h05});
    ctrl = 4'h0;
    wign(n);
    rng(n, 30, 45);
    chk(alarm[2], 32'h1);
    wt(2, 1'b0, n);
    rng(n, 0, 22);
    chk(nreq, 32'h1);
    // Clock lead presence, group target
    cfg(4, LEAD_RXCLK, 1'b1, 15'h0001, 15'h0002, TGT_GROUP, ACT_ALTERNATE, 6'h09, 1'b1, 1'b1);
    crun = 2'b01;
    wt(4, 1'b1, n);
    rng(n, 50, 62);
    chk({stgt, sact, sgrp}, {TGT_GROUP, ACT_ALTERNATE, 6'h09});
    en = 8'h00;
    crun = 2'b00;
    repeat (2) @(negedge clk);
    chk(alarm, 32'h0);
    wign(n);
    // Data lead activity on a non-switching circuit
    swc = 1'b0;
    keep = nreq;
    cfg(6, LEAD_RXD, 1'b1, 15'h0002, 15'h0004, TGT_RACK, ACT_FORCE_A, 6'h00, 1'b0, 1'b0);
    dact = 2'b01;
    wt(6, 1'b1, n);
    rng(n, 90, 102);
    @(negedge clk);
    chk(nreq, keep);
    chk({beep, led, ign}, 32'h0);
    conclude();
  end
endmodule
